// file: shared/sram_pkg.sv
// Purpose: shared constants and carriers for the burst SRAM port
// Assumes: one clock, no register bus
// Notes:   widths are fixed; structs group the pins of one role
// Contract
// - All synchronous inputs and all read data pass rising-edge registers.
// - Third select, active low, sampled only when a new address loads.
// - Output enable low drives data pins; high tri-states them.
// - First read cycle after deselect keeps outputs off regardless of enable.
// - Burst step low at an edge advances the burst counter.
// - Processor strobe low captures address and loads the low two bits.
// - Controller strobe low captures address and loads the low two bits.
// - With both strobes low only the processor strobe acts.
// - Processor strobe is ignored while the first select is high.
// - Sleep input high enters low-power sleep keeping data; low is normal.
// - Input data captured at the edge; outputs show the previous address.
// - Order strap low picks linear, high picks interleaved; keep static.
// - Two-bit wraparound counter holds burst start, supplies later beats.
// - All-bytes write writes four lanes, ignoring gate and lane selects.
// - Otherwise only lanes selected low under a low gate are written.
// - Read starts on strobe, all selects on, both write inputs high.
// - Read data reaches the pins one edge after the address capture.
// - Deselect by selects plus strobe tri-states outputs from the edge that samples it.
// - Processor-started write loads only the address in its first cycle.
// - Processor-started write takes two clocks; second edge decides bytes.
// - Any detected write cycle tri-states the data drivers.
// - First select active low, second active high, sampled with third.
// - Interleaved beat is start XOR count; linear is start plus count.
// - Controller-started write completes in one clock, ignoring burst step.
`default_nettype none

package sram_pkg;
    localparam int ADDR_W  = 16;
    localparam int DATA_W  = 32;
    localparam int LANES   = 4;
    localparam int LANE_W  = 8;
    localparam int BURST_W = 2;
    localparam int HIGH_W  = ADDR_W - BURST_W;
    localparam int DEPTH   = 65536;

    localparam logic [LANES-1:0]   LANE_ALL   = 4'hf;
    localparam logic [LANES-1:0]   LANE_NONE  = 4'h0;
    localparam logic [BURST_W-1:0] BEAT_FIRST = 2'h0;
    localparam logic [BURST_W-1:0] BEAT_STEP  = 2'h1;
    localparam logic [BURST_W-1:0] BEAT_LAST  = 2'h3;
    localparam logic [DATA_W-1:0]  DATA_RESET = 32'h0000_0000;
    localparam logic [HIGH_W-1:0]  HIGH_RESET = 14'h0000;
    localparam logic [1:0]         SYNC_LOW   = 2'h0;
    localparam logic [1:0]         SYNC_HIGH  = 2'h3;

    typedef struct packed {
        logic chip_select_primary_n;
        logic chip_select_high;
        logic chip_select_low_b;
    } select_t;

    typedef struct packed {
        logic proc_addr_strobe_n;
        logic ctrl_addr_strobe_n;
        logic burst_step_n;
    } strobe_t;

    typedef struct packed {
        logic             all_bytes_write_n;
        logic             byte_write_gate_n;
        logic [LANES-1:0] byte_lane_select_n;
    } write_ctl_t;

    typedef enum logic [2:0] {
        ACC_IDLE  = 3'b001,
        ACC_READ  = 3'b010,
        ACC_WRITE = 3'b100
    } access_t;
endpackage

`default_nettype wire

// file: hw/burst_counter.sv
// Purpose: two-bit wraparound burst address generator
// Assumes: order select already synchronised
// Notes:   start and beat kept apart so both orders share one count
`default_nettype none

module burst_counter (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       reset,
    // Control
    input  wire logic       load,
    input  wire logic [1:0] load_low,
    input  wire logic       step,
    input  wire logic       interleave,
    // Beat addresses
    output logic      [1:0] cur_low,
    output logic      [1:0] next_low
);
    logic [1:0] start_reg;
    logic [1:0] beat_reg;
    logic [1:0] beat_next;

    // First address of the burst
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            start_reg <= sram_pkg::BEAT_FIRST;
        end else if (load) begin
            start_reg <= load_low;
        end
    end

    // Beat count; load wins over a step in the same cycle
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            beat_reg <= sram_pkg::BEAT_FIRST;
        end else if (load) begin
            beat_reg <= sram_pkg::BEAT_FIRST;
        end else if (step) begin
            beat_reg <= beat_next;
        end
    end

    // Two-bit sum wraps by itself after the fourth beat
    assign beat_next = beat_reg + sram_pkg::BEAT_STEP;

    // Interleaved uses XOR, linear a modulo-four add
    assign cur_low  = interleave ? (start_reg ^ beat_reg) : (start_reg + beat_reg);
    assign next_low = interleave ? (start_reg ^ beat_next) : (start_reg + beat_next);

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    counter_wrap_a:
        assert property (beat_reg == sram_pkg::BEAT_LAST && step && !load |=> cur_low == start_reg)
        else $error("burst did not wrap to its start");

    counter_load_a:
        assert property (load |=> cur_low == $past(load_low))
        else $error("first beat differs from loaded bits");
endmodule // burst_counter

`default_nettype wire

// file: hw/sram_array.sv
// Purpose: 64K x 32 storage split into byte lanes
// Assumes: at most one write per clock
// Notes:   no reset; contents survive sleep and reset alike
`default_nettype none

module sram_array (
    // Clock
    input  wire logic                          clk_sys,
    // Write side
    input  wire logic [sram_pkg::LANES-1:0]    wr_lanes,
    input  wire logic [sram_pkg::ADDR_W-1:0]   wr_addr,
    input  wire logic [sram_pkg::DATA_W-1:0]   wr_data,
    // Read side, combinational
    input  wire logic [sram_pkg::ADDR_W-1:0]   rd_addr,
    output logic      [sram_pkg::DATA_W-1:0]   rd_data
);
    // One memory per lane so each lane has a single writer
    for (genvar g = 0; g < sram_pkg::LANES; g++) begin : g_lane
        logic [sram_pkg::LANE_W-1:0] lane_mem [sram_pkg::DEPTH];

        always_ff @(posedge clk_sys) begin
            if (wr_lanes[g]) begin
                lane_mem[wr_addr] <= wr_data[g*sram_pkg::LANE_W +: sram_pkg::LANE_W];
            end
        end

        assign rd_data[g*sram_pkg::LANE_W +: sram_pkg::LANE_W] = lane_mem[rd_addr];
    end
endmodule // sram_array

`default_nettype wire

// file: hw/sram_port.sv
// Purpose: pipelined burst SRAM port, device side
// Assumes: partner drives synchronous pins from clk_sys
// Notes:   out_enable_n gates the drivers without a clock
`default_nettype none

module sram_port (
    // Clock and reset
    input  wire logic                          clk_sys,
    input  wire logic                          reset,
    // Address and access controls
    input  wire logic [sram_pkg::ADDR_W-1:0]   address,
    input  wire sram_pkg::select_t             chip_sel,
    input  wire sram_pkg::strobe_t             strobes,
    input  wire sram_pkg::write_ctl_t          wr_ctl,
    // Asynchronous pins and strap
    input  wire logic                          out_enable_n,
    input  wire logic                          sleep_request,
    input  wire logic                          burst_interleave,
    // Shared data pins
    input  wire logic [sram_pkg::DATA_W-1:0]   dq_in,
    output logic      [sram_pkg::DATA_W-1:0]   dq_out,
    output logic                               dq_oe
);
    logic [1:0]                  sleep_sync_reg;
    logic [1:0]                  order_sync_reg;
    logic                        sleeping;
    logic                        interleave;

    logic                        proc_start;
    logic                        ctrl_start;
    logic                        new_addr;
    logic                        chip_on;
    logic                        deselect;
    logic                        write_ask;
    logic                        read_begin;
    logic                        ctrl_addr_strobe_n_write;
    logic                        cont_cycle;
    logic                        cont_write;
    logic                        cont_read;
    logic                        write_now;
    logic                        step_now;
    logic                        load_now;
    logic [sram_pkg::LANES-1:0]  lane_sel;
    logic [sram_pkg::LANES-1:0]  wr_lanes;

    logic [sram_pkg::HIGH_W-1:0] addr_high_reg;
    logic [1:0]                  cur_low;
    logic [1:0]                  next_low;
    logic [1:0]                  wr_low;
    logic [sram_pkg::ADDR_W-1:0] wr_addr;
    logic [sram_pkg::ADDR_W-1:0] rd_addr;
    logic [sram_pkg::DATA_W-1:0] rd_data;

    sram_pkg::access_t           acc_state_reg;
    sram_pkg::access_t           acc_state_next;
    logic                        read_pending;
    logic [sram_pkg::DATA_W-1:0] data_out_reg;
    logic                        drive_reg;

    // Sleep pin is asynchronous: two stages, which also gives
    // the two-cycle entry and exit
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            sleep_sync_reg <= sram_pkg::SYNC_LOW;
        end else begin
            sleep_sync_reg <= {sleep_sync_reg[0], sleep_request};
        end
    end

    // Order strap; reset value matches the internal pull-up
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            order_sync_reg <= sram_pkg::SYNC_HIGH;
        end else begin
            order_sync_reg <= {order_sync_reg[0], burst_interleave};
        end
    end

    assign sleeping   = sleep_sync_reg[1];
    assign interleave = order_sync_reg[1];

    // Cycle decode on the pins as sampled at this edge
    always_comb begin
        // Processor strobe needs the first select; asleep means ignore
        proc_start = ~sleeping
                   & ~strobes.proc_addr_strobe_n
                   & ~chip_sel.chip_select_primary_n;
        // Controller strobe only when the processor strobe is not acting
        ctrl_start = ~sleeping
                   & ~strobes.ctrl_addr_strobe_n
                   & ~proc_start;
        new_addr   = proc_start | ctrl_start;
        // Selects only matter when an address loads
        chip_on    = ~chip_sel.chip_select_primary_n
                   & chip_sel.chip_select_high
                   & ~chip_sel.chip_select_low_b;
        deselect   = new_addr & ~chip_on;
        write_ask  = ~wr_ctl.all_bytes_write_n | ~wr_ctl.byte_write_gate_n;
        // Processor start is always an address load, writes wait a cycle
        read_begin = new_addr & chip_on & (proc_start | ~write_ask);
        ctrl_addr_strobe_n_write = ctrl_start & chip_on & write_ask;
        // With no strobe acting, a live burst continues
        cont_cycle = ~sleeping & ~new_addr
                   & (acc_state_reg != sram_pkg::ACC_IDLE);
        cont_write = cont_cycle & write_ask;
        cont_read  = cont_cycle & ~write_ask;
        write_now  = ctrl_addr_strobe_n_write | cont_write;
        // Step is ignored on every address-load cycle
        step_now   = cont_cycle & ~strobes.burst_step_n;
        load_now   = new_addr & chip_on;
    end

    // Byte lane choice: all-bytes write overrides the lane selects
    always_comb begin
        if (!wr_ctl.all_bytes_write_n) begin
            lane_sel = sram_pkg::LANE_ALL;
        end else if (!wr_ctl.byte_write_gate_n) begin
            lane_sel = ~wr_ctl.byte_lane_select_n;
        end else begin
            lane_sel = sram_pkg::LANE_NONE;
        end
        wr_lanes = write_now ? lane_sel : sram_pkg::LANE_NONE;
    end

    // Upper address bits captured on every accepted strobe
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            addr_high_reg <= sram_pkg::HIGH_RESET;
        end else if (load_now) begin
            addr_high_reg <= address[sram_pkg::ADDR_W-1:sram_pkg::BURST_W];
        end
    end

    // Low bits live in the wraparound counter
    burst_counter u_counter (
        .clk_sys    (clk_sys),
        .reset      (reset),
        .load       (load_now),
        .load_low   (address[sram_pkg::BURST_W-1:0]),
        .step       (step_now),
        .interleave (interleave),
        .cur_low    (cur_low),
        .next_low   (next_low)
    );

    // Write address: pins for a controller write, else the burst beat;
    // a stepped continue writes the next beat
    always_comb begin
        wr_low = step_now ? next_low : cur_low;
        if (ctrl_addr_strobe_n_write) begin
            wr_addr = address;
        end else begin
            wr_addr = {addr_high_reg, wr_low};
        end
    end

    assign rd_addr = {addr_high_reg, cur_low};

    // Storage; write data taken straight off the pins at the edge
    sram_array u_array (
        .clk_sys  (clk_sys),
        .wr_lanes (wr_lanes),
        .wr_addr  (wr_addr),
        .wr_data  (dq_in),
        .rd_addr  (rd_addr),
        .rd_data  (rd_data)
    );

    // Access state; sleep and deselect end any burst
    always_comb begin
        acc_state_next = acc_state_reg;
        if (sleeping || deselect) begin
            acc_state_next = sram_pkg::ACC_IDLE;
        end else if (read_begin || cont_read) begin
            acc_state_next = sram_pkg::ACC_READ;
        end else if (write_now) begin
            acc_state_next = sram_pkg::ACC_WRITE;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            acc_state_reg <= sram_pkg::ACC_IDLE;
        end else begin
            acc_state_reg <= acc_state_next;
        end
    end

    // A read address registered last edge has data to present now
    always_comb begin
        unique case (acc_state_reg)
            sram_pkg::ACC_IDLE:  read_pending = 1'b0;
            sram_pkg::ACC_READ:  read_pending = 1'b1;
            sram_pkg::ACC_WRITE: read_pending = 1'b0;
            default:             read_pending = 1'b0;
        endcase
    end

    // Output register: array word for the previous edge's address
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            data_out_reg <= sram_pkg::DATA_RESET;
        end else if (read_pending) begin
            data_out_reg <= rd_data;
        end
    end

    // Drive permission; coming out of idle there is no pending read,
    // so the first cycle of a new access stays off
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            drive_reg <= 1'b0;
        end else begin
            drive_reg <= read_pending & ~write_now & ~deselect & ~sleeping;
        end
    end

    // Enable pin acts without a clock; a write on the pins also cuts the
    // drivers at once, guarding against a partner that forgot the enable
    assign dq_oe  = drive_reg & ~out_enable_n & ~write_now & ~sleeping;
    assign dq_out = data_out_reg;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    read_pipe_a:
        assert property (read_begin && !sleeping |=> ##1 data_out_reg == $past(rd_data))
        else $error("read word not registered one edge after capture");

    first_mask_a:
        assert property (acc_state_reg == sram_pkg::ACC_IDLE && read_begin |=> !drive_reg)
        else $error("drivers on in first read cycle after deselect");

    deselect_off_a:
        assert property (deselect |=> !dq_oe)
        else $error("outputs still driven after deselect");

    write_off_a:
        assert property (write_now |-> !dq_oe ##1 !drive_reg)
        else $error("drivers on during a write cycle");

    enable_gate_a:
        assert property (out_enable_n |-> !dq_oe)
        else $error("drivers on with enable high");

    both_strobes_a:
        assert property (proc_start && !strobes.ctrl_addr_strobe_n |-> wr_lanes == sram_pkg::LANE_NONE)
        else $error("controller strobe acted beside processor strobe");

    proc_ignored_a:
        assert property (strobes.ctrl_addr_strobe_n && chip_sel.chip_select_primary_n
                         |=> $stable(addr_high_reg))
        else $error("processor strobe taken with first select high");

    addr_capture_a:
        assert property (load_now |=> addr_high_reg == $past(address[sram_pkg::ADDR_W-1:sram_pkg::BURST_W])
                                      && cur_low == $past(address[sram_pkg::BURST_W-1:0]))
        else $error("address not captured on strobe");

    all_lanes_a:
        assert property (write_now && !wr_ctl.all_bytes_write_n |-> wr_lanes == sram_pkg::LANE_ALL)
        else $error("all-bytes write missed a lane");

    proc_write_a:
        assert property (proc_start && chip_on |-> wr_lanes == sram_pkg::LANE_NONE
                         ##1 acc_state_reg == sram_pkg::ACC_READ)
        else $error("processor start wrote or failed to load");

    sleep_quiet_a:
        assert property (sleeping |-> !dq_oe && wr_lanes == sram_pkg::LANE_NONE && !load_now)
        else $error("activity while asleep");

    sleep_entry_a:
        assert property (sleep_request [*2] |=> sleeping)
        else $error("sleep not entered after two edges");

    // Strobe and lane decode; a slip here corrupts memory without a visible read
    ctrl_write_a:
        assert property (ctrl_addr_strobe_n_write |-> wr_addr == address && !step_now)
        else $error("controller write not single-edge at pin address");

    ctrl_load_a:
        assert property (ctrl_start && chip_on
                         |=> addr_high_reg == $past(address[sram_pkg::ADDR_W-1:sram_pkg::BURST_W]))
        else $error("controller strobe did not capture address");

    read_start_a:
        assert property (new_addr && chip_on && wr_ctl.all_bytes_write_n && wr_ctl.byte_write_gate_n
                         |=> acc_state_reg == sram_pkg::ACC_READ)
        else $error("read not started with write inputs high");

    byte_lanes_a:
        assert property (write_now && wr_ctl.all_bytes_write_n |-> wr_lanes == ~wr_ctl.byte_lane_select_n)
        else $error("byte write touched an unselected lane");

    proc_gate_a:
        assert property (!strobes.proc_addr_strobe_n && chip_sel.chip_select_primary_n
                         && strobes.ctrl_addr_strobe_n |-> !load_now)
        else $error("processor strobe loaded with first select high");
endmodule // sram_port

`default_nettype wire

// file: tb/bus_master.sv
// Purpose: processor-side model that drives the burst SRAM pins
// Assumes: device samples every synchronous pin on the rising clk_sys edge
// Notes:   pins move only after the falling edge; idle data lines carry noise
`default_nettype none

module bus_master (
    // Clock
    input  wire logic                        clk_sys,
    // Pins toward the device
    output var logic [sram_pkg::ADDR_W-1:0]  address,
    output var sram_pkg::select_t            chip_sel,
    output var sram_pkg::strobe_t            strobes,
    output var sram_pkg::write_ctl_t         wr_ctl,
    output var logic                         out_enable_n,
    output var logic                         sleep_request,
    output var logic                         burst_interleave,
    output var logic [sram_pkg::DATA_W-1:0]  dq_drive
);
    timeunit 1ns;
    timeprecision 1ps;

    // Patterns as {selects, strobes}: four where the second or third select refuses, one controller strobe refused by a high first select
    localparam logic [5:0] DESEL [5] = '{6'b110_101, 6'b000_011, 6'b011_011, 6'b000_101, 6'b011_101};

    // Pins start deselected, strap on interleaved, drivers of the device off
    initial begin
        address          = 16'h0000;
        chip_sel         = 3'b101;
        strobes          = 3'b111;
        wr_ctl           = 6'h3f;
        out_enable_n     = 1'b1;
        sleep_request    = 1'b0;
        burst_interleave = 1'b1;
        dq_drive         = 32'h0000_0000;
    end

    // One bus cycle, held from the falling edge through the next rising edge
    task automatic cycle(input logic [15:0] a, input logic [2:0] sel, input logic [2:0] str,
                         input logic [5:0] wc, input logic oe_n, input logic [31:0] d);
        @(negedge clk_sys);
        address      <= a;
        chip_sel     <= sel;
        strobes      <= str;
        wr_ctl       <= wc;
        out_enable_n <= oe_n;
        dq_drive     <= d;
    endtask

    // Quiet cycles; selects wander since no strobe asks for them
    task automatic idle(input int n, input logic oe_n);
        repeat (n) cycle(16'($urandom), 3'($urandom), 3'b111, 6'h3f, oe_n, $urandom);
    endtask

    // Single-edge write; burst step left random since it is ignored here
    task automatic ctrl_write(input logic [15:0] a, input logic [5:0] wc, input logic [31:0] d,
                              input logic oe_n);
        cycle(a, 3'b010, {2'b10, 1'($urandom)}, wc, oe_n, d);
    endtask

    // Two-edge write: garbage controls on the address edge, real ones after
    task automatic proc_write(input logic [15:0] a, input logic [5:0] wc, input logic [31:0] d);
        cycle(a, 3'b010, {2'b01, 1'($urandom)}, 6'($urandom), 1'b1, $urandom);
        cycle(16'($urandom), 3'($urandom), 3'b111, wc, 1'b1, d);
    endtask

    task automatic deselect(input int idx, input logic oe_n);
        cycle(16'($urandom), DESEL[idx][5:3], DESEL[idx][2:0], 6'h3f, oe_n, $urandom);
    endtask

    // Strap and sleep only move while the device is deselected
    task automatic set_pins(input logic order, input logic sleep);
        @(negedge clk_sys);
        burst_interleave <= order;
        sleep_request    <= sleep;
    endtask
endmodule // bus_master

`default_nettype wire

// file: tb/testbench.sv
// Purpose: self-checking bench for the burst SRAM port
// Assumes: bus_master drives every device pin after the falling edge
// Notes:   expected beats are queued by the driver, checked by the monitor
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    logic                 clk_sys = 1'b0;
    logic                 reset   = 1'b1;
    logic [15:0]          address;
    sram_pkg::select_t    chip_sel;
    sram_pkg::strobe_t    strobes;
    sram_pkg::write_ctl_t wr_ctl;
    logic                 out_enable_n;
    logic                 sleep_request;
    logic                 burst_interleave;
    logic [31:0]          dq_drive;
    logic [31:0]          dq_in;
    logic [31:0]          dq_out;
    logic                 dq_oe;
    int                   errors  = 0;
    int                   n_tests = 0;
    logic [31:0]          exp_q [$];
    logic [31:0]          mem_model [logic [15:0]];
    logic                 order;

    always #10 clk_sys = ~clk_sys;

    // Shared data wire: device wins only while it drives
    assign dq_in = dq_oe ? dq_out : dq_drive;

    bus_master host (
        .clk_sys(clk_sys), .address(address), .chip_sel(chip_sel), .strobes(strobes),
        .wr_ctl(wr_ctl), .out_enable_n(out_enable_n), .sleep_request(sleep_request),
        .burst_interleave(burst_interleave), .dq_drive(dq_drive)
    );

    sram_port uut (
        .clk_sys(clk_sys), .reset(reset), .address(address), .chip_sel(chip_sel),
        .strobes(strobes), .wr_ctl(wr_ctl), .out_enable_n(out_enable_n),
        .sleep_request(sleep_request), .burst_interleave(burst_interleave),
        .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe)
    );

    task automatic check_word(input logic [31:0] got, input logic [31:0] want);
        n_tests++;
        if (got !== want) begin
            errors++;
            $display("wrong value at %0t: read %h, expected %h", $time, got, want);
        end
    endtask

    task automatic complete_run;
        if (exp_q.size() != 0) begin
            errors++;
            $display("wrong value at %0t: %0d beats never driven", $time, exp_q.size());
        end
        if (errors == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Any drive must match the oldest note; a drive with no note is wrong
    always @(posedge clk_sys) begin
        if (!reset && dq_oe !== 1'b0) begin
            if (dq_oe !== 1'b1 || exp_q.size() == 0) begin
                n_tests++;
                errors++;
                $display("wrong value at %0t: data pins driven unexpectedly", $time);
            end else begin
                check_word(dq_out, exp_q.pop_front());
            end
        end
    end

    // Beat address inside the aligned group of four
    function automatic logic [1:0] beat(input logic [1:0] s, input int k, input logic il);
        return il ? (s ^ 2'(k)) : (s + 2'(k));
    endfunction

    task automatic model_write(input logic [15:0] a, input logic [5:0] wc, input logic [31:0] d);
        logic [3:0] ln;
        ln = !wc[5] ? 4'hf : (wc[4] ? 4'h0 : ~wc[3:0]);
        for (int i = 0; i < 4; i++)
            if (ln[i]) mem_model[a][8*i +: 8] = d[8*i +: 8];
    endtask

    // Start a read, then n continue edges with step low, all selects random and a processor strobe only under a high first select
    task automatic read_burst(input logic [15:0] a, input logic via_ctrl, input int n, input logic oe_n);
        logic [2:0] sel;
        host.cycle(a, 3'b010, via_ctrl ? 3'b101 : 3'b011, 6'h3f, oe_n, $urandom);
        for (int k = 1; k <= n; k++) begin
            sel = 3'($urandom);
            host.cycle(16'($urandom), sel, {sel[2] ? 1'($urandom) : 1'b1, 2'b10}, 6'h3f, oe_n, $urandom);
            if (!oe_n) exp_q.push_back(mem_model[{a[15:2], beat(a[1:0], k - 1, order)}]);
        end
    endtask

    // Hang guard
    initial begin
        repeat (20000) @(posedge clk_sys);
        errors++;
        $display("wrong value at %0t: run did not finish", $time);
        complete_run();
    end

    initial begin
        logic [15:0] base;
        logic [15:0] a;
        logic [31:0] d;
        logic [5:0]  wc;
        logic        oe_n;
        void'($urandom(32'h14c3));
        repeat (16) @(posedge clk_sys);
        @(negedge clk_sys);
        reset = 1'b0;
        host.idle(2, 1'b1);
        for (int t = 0; t < 24; t++) begin
            base  = {14'($urandom), 2'b00};
            order = t[0];
            host.set_pins(order, 1'b0);
            host.idle(3, 1'b1);
            // Fill the group whole so no read returns an unknown word
            for (int i = 0; i < 4; i++) begin
                d = $urandom;
                host.ctrl_write(base + 16'(i), 6'h1f, d, 1'b1);
                mem_model[base + 16'(i)] = d;
            end
            host.deselect(int'($urandom_range(4)), 1'b1);
            // Lane writes by either strobe; a gate-high, global-high pair would be a read
            wc = 6'($urandom);
            if (wc[5] && wc[4]) wc[4] = 1'b0;
            a = base + 16'($urandom_range(3));
            d = $urandom;
            if (t[1]) host.ctrl_write(a, wc, d, 1'b1);
            else host.proc_write(a, wc, d);
            model_write(a, wc, d);
            host.deselect(int'($urandom_range(4)), 1'b1);
            // Both strobes low: processor wins, so no write lands
            host.cycle(base + 16'($urandom_range(3)), 3'b010, 3'b001, 6'h1f, 1'b1, $urandom);
            host.deselect(int'($urandom_range(4)), 1'b1);
            oe_n = (t % 5 == 4);
            read_burst(base + 16'($urandom_range(3)), t[2], 1 + int'($urandom_range(5)), oe_n);
            if (t % 4 == 3 && !oe_n) begin
                // Write on the last beat's cycle hides that beat despite a low enable
                void'(exp_q.pop_back());
                d = $urandom;
                host.ctrl_write(base, 6'h1f, d, 1'b0);
                mem_model[base] = d;
                host.deselect(int'($urandom_range(4)), 1'b1);
            end else begin
                host.deselect(int'($urandom_range(4)), oe_n);
            end
            host.idle(2, oe_n);
        end
        // Asleep: a write and a read are both ignored, pins stay off
        host.set_pins(order, 1'b1);
        host.idle(3, 1'b1);
        host.ctrl_write(base, 6'h1f, ~mem_model[base], 1'b0);
        host.deselect(0, 1'b0);
        host.cycle(base, 3'b010, 3'b011, 6'h3f, 1'b0, $urandom);
        host.idle(3, 1'b0);
        host.set_pins(order, 1'b0);
        host.idle(3, 1'b1);
        read_burst(base, 1'b0, 4, 1'b0);
        host.deselect(0, 1'b0);
        host.idle(3, 1'b1);
        complete_run();
    end
endmodule // testbench

`default_nettype wire
